// ==== hw/srq_params.svh ====
// Constants for the service-request, status byte and bus hold-off block.
// Assumes a 100 MHz core clock; included only by the block's top-level design file.
`ifndef SRQ_PARAMS_SVH
`define SRQ_PARAMS_SVH

`define STB_OVERFLOW_POS 0
`define STB_FULL_POS 1
`define STB_DONE_POS 3
`define STB_READY_POS 4
`define STB_ERROR_POS 5
`define STB_RQS_POS 6
`define STB_WIDTH 8
`define MASK_WRITABLE 8'h3B
`define MASK_RESET 8'h00
`define CLK_KHZ 100000
`define CAL_HOLD_MS 13
`define CFG_HOLD_MS 20
`define VALUE_HOLD_MS 360
`define STORE_DEPTH 100

`endif

// ==== hw/srq_pkg.sv ====
// Types shared by the service-request and hold-off block.
// Assumes nothing beyond a SystemVerilog compiler.
package srq_pkg;

  // Encoded as the end-control command number
  typedef enum logic [1:0] {
    eoi_and_holdoff_mode = 2'h0,
    holdoff_only_mode = 2'h1,
    eoi_only_mode = 2'h2,
    no_eoi_no_holdoff_mode = 2'h3
  } end_mode_type;

  // What the executed command string asks the front end to do
  typedef enum logic [1:0] {
    cls_other = 2'h0,
    cls_cal_store = 2'h1,
    cls_config = 2'h2,
    cls_zero_suppress = 2'h3
  } cmd_class_type;

  typedef enum logic [3:0] {
    ho_idle = 4'h1,
    ho_byte = 4'h2,
    ho_timed = 4'h4,
    ho_value = 4'h8
  } holdoff_state_type;

  typedef struct packed {
    logic illegal_command_error;
    logic illegal_option_error;
    logic trigger_overrun;
    logic number_error;
  } err_events_type;

  typedef struct packed {
    logic byte_rcvd;
    logic exec_char;
    cmd_class_type cls;
  } rx_byte_type;

endpackage : srq_pkg

// ==== hw/pin_sync.sv ====
// Two-stage synchroniser for bus pins that arrive from outside the clock domain.
// Assumes inputs are levels held for several core clock periods.
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk, // Core clock
  input wire logic nrst, // Async reset, active low
  input wire logic clk_en, // Freezes the stages when low
  input wire logic [WIDTH-1:0] pin_in, // Raw pin levels
  output logic [WIDTH-1:0] pin_sync_out // Synchronised levels
);
  logic [WIDTH-1:0] stage1_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync needs WIDTH of at least 1");
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stage1_reg <= '0;
      pin_sync_out <= '0;
    end else if (clk_en) begin
      stage1_reg <= pin_in;
      pin_sync_out <= stage1_reg;
    end
  end
endmodule : pin_sync

// ==== hw/holdoff_timer.sv ====
// Down-counter that times one bus hold-off interval.
// Assumes load is only pulsed while the counter is idle.
`timescale 1ns/1ns
module holdoff_timer #(
  parameter int WIDTH = 22
) (
  input wire logic core_clk, // Core clock
  input wire logic nrst, // Async reset, active low
  input wire logic clk_en, // Freezes the count when low
  input wire logic load, // Start a new interval
  input wire logic [WIDTH-1:0] load_cycles, // Interval length in cycles
  output logic done // One-cycle pulse at interval end
);
  logic [WIDTH-1:0] count_reg;
  logic running_reg;

  if (WIDTH < 2) begin : g_bad_width
    $error("holdoff_timer needs WIDTH of at least 2");
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
      running_reg <= 1'b0;
      done <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (load) begin
        count_reg <= load_cycles;
        running_reg <= 1'b1;
      end else if (running_reg) begin
        if (count_reg <= WIDTH'(1)) begin
          running_reg <= 1'b0;
          done <= 1'b1;
        end else begin
          count_reg <= count_reg - WIDTH'(1);
        end
      end
    end
  end
endmodule : holdoff_timer

// ==== hw/gpib_status_srq_holdoff.sv ====
// Status byte, service request and NRFD/EOI end-control for a bus instrument.
// Assumes command parsing, triggering and the talker run on core_clk and
// hand over one-cycle event pulses; only the REN pin is asynchronous.
`timescale 1ns/1ns
`include "srq_params.svh"
module gpib_status_srq_holdoff #(
  parameter int CAL_HOLD_CYC = `CAL_HOLD_MS * `CLK_KHZ,
  parameter int CFG_HOLD_CYC = `CFG_HOLD_MS * `CLK_KHZ,
  parameter int TIMER_WIDTH = 22
) (
  input wire logic core_clk, // 100 MHz core clock
  input wire logic nrst, // Async reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic ren_pin, // REN bus line level, high = remote
  input wire logic dev_clear, // DCL or SDC received, pulse
  input wire srq_pkg::rx_byte_type rx, // Received byte info, pulse
  input wire logic byte_recognized, // Parser recognized last byte, pulse
  input wire logic value_taken, // Zero/suppress value taken, pulse
  input wire srq_pkg::err_events_type err_ev, // Error events, pulses
  input wire logic overrange_event, // Overrange reading, pulse
  input wire logic vi_current_overload, // Overload is V/I ohms current, level
  input wire logic good_reading, // Non-overflowed reading ready, pulse
  input wire logic store_full_event, // Store reached its capacity, pulse
  input wire logic store_read, // Stored reading read over bus, pulse
  input wire logic reading_done, // Conversion completed, pulse
  input wire logic reading_request, // Reading requested over bus, pulse
  input wire logic error_word_query, // Error word was read, pulse
  input wire logic mask_write, // Mask command executed, pulse
  input wire logic [7:0] mask_value, // Mask command value
  input wire logic mode_write, // End-control command executed, pulse
  input wire srq_pkg::end_mode_type mode_value, // End-control mode
  input wire logic spoll_read, // Serial poll read the byte, pulse
  input wire logic last_byte_out, // Talker sending final byte, level
  output logic [7:0] status_byte, // Serial poll response
  output logic srq_o, // SRQ pin output level
  output logic srq_oe, // SRQ pin drive enable
  output logic nrfd_o, // NRFD pin output level
  output logic nrfd_oe, // NRFD pin drive enable
  output logic eoi_o, // EOI pin output level
  output logic eoi_oe, // EOI pin drive enable
  output srq_pkg::end_mode_type end_mode // Current end-control mode
);
  if (CAL_HOLD_CYC < 1 || CFG_HOLD_CYC < 1) begin : g_bad_hold
    $error("hold-off cycle counts must be at least one");
  end
  if (CAL_HOLD_CYC >= (1 << TIMER_WIDTH) || CFG_HOLD_CYC >= (1 << TIMER_WIDTH)) begin : g_bad_w
    $error("TIMER_WIDTH too small for hold-off counts");
  end

  function automatic logic holdoff_on(input srq_pkg::end_mode_type m);
    holdoff_on = (m == srq_pkg::eoi_and_holdoff_mode) || (m == srq_pkg::holdoff_only_mode);
  endfunction : holdoff_on

  function automatic logic eoi_on(input srq_pkg::end_mode_type m);
    eoi_on = (m == srq_pkg::eoi_and_holdoff_mode) || (m == srq_pkg::eoi_only_mode);
  endfunction : eoi_on

  logic ren_sync;
  logic ovf_reg;
  logic full_reg;
  logic done_reg;
  logic err_reg;
  logic err_srq_en_reg;
  logic srq_reg;
  logic req_prev_reg;
  logic [7:0] mask_reg;
  logic [7:0] frozen_reg;
  logic [7:0] live_byte;
  logic [7:0] masked;
  logic request;
  logic raise;
  logic any_error;
  logic ready;
  logic timer_load;
  logic timer_done;
  logic [TIMER_WIDTH-1:0] timer_cycles;
  srq_pkg::holdoff_state_type ho_reg;
  srq_pkg::holdoff_state_type ho_next;

  pin_sync #(.WIDTH(1)) u_ren_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .pin_in(ren_pin),
    .pin_sync_out(ren_sync)
  );

  holdoff_timer #(.WIDTH(TIMER_WIDTH)) u_timer (
    .core_clk(core_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .load(timer_load),
    .load_cycles(timer_cycles),
    .done(timer_done)
  );

  // A command arriving while not in remote counts as an error
  assign any_error = (|err_ev) || (rx.byte_rcvd && !ren_sync);

  // Error bit: set wins over the clear by the error word read
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      err_reg <= 1'b0;
    end else if (clk_en) begin
      if (any_error) begin
        err_reg <= 1'b1;
      end else if (error_word_query || dev_clear) begin
        err_reg <= 1'b0;
      end
    end
  end

  // Live condition bits
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ovf_reg <= 1'b0;
      full_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (clk_en) begin
      if (overrange_event && !vi_current_overload) begin
        ovf_reg <= 1'b1;
      end else if (good_reading) begin
        ovf_reg <= 1'b0;
      end
      if (store_full_event) begin
        full_reg <= 1'b1;
      end else if (store_read) begin
        full_reg <= 1'b0;
      end
      if (reading_done) begin
        done_reg <= 1'b1;
      end else if (reading_request) begin
        done_reg <= 1'b0;
      end
    end
  end

  assign ready = (ho_reg == srq_pkg::ho_idle) && !rx.byte_rcvd;

  always_comb begin
    live_byte = 8'h00;
    live_byte[`STB_OVERFLOW_POS] = ovf_reg;
    live_byte[`STB_FULL_POS] = full_reg;
    live_byte[`STB_DONE_POS] = done_reg;
    live_byte[`STB_READY_POS] = ready;
    live_byte[`STB_ERROR_POS] = err_reg;
  end

  // Mask register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mask_reg <= `MASK_RESET;
    end else if (clk_en) begin
      if (dev_clear) begin
        mask_reg <= `MASK_RESET;
      end else if (mask_write) begin
        mask_reg <= mask_value & `MASK_WRITABLE;
      end
    end
  end

  // An error SRQ is not repeated until software has read the error word or a device clear arrives
  assign masked = live_byte & mask_reg;
  assign request = (|masked[4:0]) || (masked[`STB_ERROR_POS] && err_srq_en_reg);
  assign raise = request && !req_prev_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      req_prev_reg <= 1'b0;
      err_srq_en_reg <= 1'b1;
    end else if (clk_en) begin
      req_prev_reg <= request;
      if (error_word_query || dev_clear) begin
        err_srq_en_reg <= 1'b1;
      end else if (raise && masked[`STB_ERROR_POS]) begin
        err_srq_en_reg <= 1'b0;
      end
    end
  end

  // SRQ and frozen byte; while SRQ is set, a poll wins over a new request in the same cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      srq_reg <= 1'b0;
      frozen_reg <= 8'h00;
    end else if (clk_en) begin
      if (raise && !srq_reg) begin
        srq_reg <= 1'b1;
        frozen_reg <= live_byte | (8'h01 << `STB_RQS_POS);
      end else if (spoll_read || dev_clear) begin
        srq_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      status_byte <= 8'h00;
    end else if (clk_en) begin
      status_byte <= srq_reg ? frozen_reg : live_byte;
    end
  end

  assign srq_o = 1'b0;
  assign srq_oe = srq_reg;

  // End-control mode
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      end_mode <= srq_pkg::eoi_and_holdoff_mode;
    end else if (clk_en) begin
      if (dev_clear) begin
        end_mode <= srq_pkg::eoi_and_holdoff_mode;
      end else if (mode_write) begin
        end_mode <= mode_value;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      eoi_oe <= 1'b0;
    end else if (clk_en) begin
      eoi_oe <= last_byte_out && eoi_on(end_mode);
    end
  end
  assign eoi_o = 1'b0;

  // Hold-off sequencer. The execute byte's handshake has already finished
  // when rx.byte_rcvd pulses, so NRFD only holds the following byte.
  always_comb begin
    ho_next = ho_reg;
    timer_load = 1'b0;
    timer_cycles = TIMER_WIDTH'(CFG_HOLD_CYC);
    case (ho_reg)
      srq_pkg::ho_idle: begin
        if (rx.byte_rcvd) begin
          ho_next = srq_pkg::ho_byte;
          if (rx.exec_char && holdoff_on(end_mode)) begin
            case (rx.cls)
              srq_pkg::cls_cal_store: begin
                ho_next = srq_pkg::ho_timed;
                timer_load = 1'b1;
                timer_cycles = TIMER_WIDTH'(CAL_HOLD_CYC);
              end
              srq_pkg::cls_config: begin
                ho_next = srq_pkg::ho_timed;
                timer_load = 1'b1;
              end
              srq_pkg::cls_zero_suppress: begin
                ho_next = srq_pkg::ho_value;
              end
              default: begin
                ho_next = srq_pkg::ho_byte;
              end
            endcase
          end
        end
      end
      srq_pkg::ho_byte: begin
        if (byte_recognized) begin
          ho_next = srq_pkg::ho_idle;
        end
      end
      srq_pkg::ho_timed: begin
        if (timer_done) begin
          ho_next = srq_pkg::ho_idle;
        end
      end
      srq_pkg::ho_value: begin
        if (value_taken) begin
          ho_next = srq_pkg::ho_idle;
        end
      end
      default: begin
        ho_next = srq_pkg::ho_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ho_reg <= srq_pkg::ho_idle;
    end else if (clk_en) begin
      ho_reg <= dev_clear ? srq_pkg::ho_idle : ho_next;
    end
  end

  assign nrfd_o = 1'b0;
  assign nrfd_oe = (ho_reg != srq_pkg::ho_idle);

  // Checks
  chk_rqs_on_srq: assert property (@(posedge core_clk) disable iff (!nrst)
    srq_oe |=> status_byte[`STB_RQS_POS])
    else $error("RQS bit clear while SRQ driven");
  chk_err_sets: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && (|err_ev) |=> err_reg)
    else $error("error event did not set error bit");
  chk_err_srq: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && !srq_reg && mask_reg[5] && err_srq_en_reg && !req_prev_reg && err_reg
      |=> srq_oe)
    else $error("masked error did not raise SRQ");
  chk_u1_clears: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && error_word_query && !any_error |=> !err_reg && err_srq_en_reg)
    else $error("error word read did not clear error");
  chk_zero_bits: assert property (@(posedge core_clk) disable iff (!nrst)
    status_byte[2] == 1'b0 && status_byte[7] == 1'b0)
    else $error("unused status bits not zero");
  chk_frozen_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    srq_reg && clk_en && !spoll_read && !dev_clear ##1 srq_reg && clk_en
      |=> $stable(status_byte))
    else $error("status byte changed while frozen");
  chk_poll_release: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && srq_reg && spoll_read && !raise |=> !srq_oe ##1 !status_byte[6] || !clk_en)
    else $error("serial poll did not release SRQ");
  chk_mode_clear: assert property (@(posedge core_clk) disable iff (!nrst)
    clk_en && dev_clear |=> end_mode == srq_pkg::eoi_and_holdoff_mode && mask_reg == 8'h00)
    else $error("device clear did not restore defaults");
  chk_cal_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    ho_reg == srq_pkg::ho_idle && ho_next == srq_pkg::ho_timed && clk_en && !dev_clear
      |=> nrfd_oe)
    else $error("hold-off not asserted after execute");
  chk_mask_bit6: assert property (@(posedge core_clk) disable iff (!nrst)
    mask_reg[6] == 1'b0 && mask_reg[2] == 1'b0 && mask_reg[7] == 1'b0)
    else $error("unused mask bit set");
endmodule : gpib_status_srq_holdoff

// ==== testbench/bus_controller_model.sv ====
// Bus controller that answers SRQ with a serial poll after a set delay.
// Assumes the SRQ line is already resolved with its pull-up by the caller.
`timescale 1ns/1ns
module bus_controller_model (
  input wire logic core_clk, // Core clock
  input wire logic nrst, // Async reset, active low
  input wire logic srq_line, // Resolved SRQ level, low = request
  input wire logic [7:0] status_byte, // Byte offered by the device
  input wire logic poll_en, // Allows polling at all
  input wire logic [7:0] poll_delay, // Cycles between SRQ seen and poll
  output logic spoll_read, // One-cycle serial poll pulse
  output logic [7:0] polled_byte, // Byte taken by the last poll
  output int poll_count // Number of polls done
);
  // A slow controller leaves SRQ standing; the device must not care
  initial begin
    spoll_read = 1'b0;
    polled_byte = 8'h00;
    poll_count = 0;
    forever begin
      @(posedge core_clk);
      if (nrst && poll_en && srq_line === 1'b0) begin
        repeat (poll_delay) @(posedge core_clk);
        spoll_read <= 1'b1;
        @(posedge core_clk);
        polled_byte = status_byte;
        spoll_read <= 1'b0;
        poll_count++;
        repeat (2) @(posedge core_clk);
      end
    end
  end
endmodule : bus_controller_model

// ==== testbench/testbench.sv ====
// Self-checking bench for the status byte, SRQ and NRFD/EOI block.
// Assumes the controller model polls on SRQ; pins resolved with pull-ups here.
`timescale 1ns/1ns
module testbench;
  localparam int CAL = 20;
  localparam int CFG = 30;
  logic core_clk = 1'b0, nrst = 1'b0, ren_pin = 1'b1, vi = 1'b0, last_out = 1'b0;
  logic poll_en = 1'b1, clk_en = 1'b1;
  logic [11:0] ev_vec = 12'h000;
  logic [7:0] mask_v = 8'h00, poll_delay = 8'h01, fr;
  srq_pkg::rx_byte_type rx_v = '0;
  srq_pkg::err_events_type err_v = '0;
  srq_pkg::end_mode_type mode_v = srq_pkg::eoi_and_holdoff_mode;
  srq_pkg::end_mode_type end_mode;
  logic [7:0] status_byte, polled_byte;
  logic srq_o, srq_oe, nrfd_o, nrfd_oe, eoi_o, eoi_oe, spoll_read;
  int poll_count, fails = 0, checked = 0, seed = 24670, op;
  logic m_ovf = 1'b0, m_full = 1'b0, m_done = 1'b0, m_err = 1'b0, r;
  wire srq_line = srq_oe ? srq_o : 1'b1;
  wire nrfd_line = nrfd_oe ? nrfd_o : 1'b1;
  wire eoi_line = eoi_oe ? eoi_o : 1'b1;

  always #5 core_clk = ~core_clk;

  gpib_status_srq_holdoff #(.CAL_HOLD_CYC(CAL), .CFG_HOLD_CYC(CFG), .TIMER_WIDTH(22)) dut (
    .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .ren_pin(ren_pin),
    .dev_clear(ev_vec[9]), .rx(rx_v), .byte_recognized(ev_vec[8]), .value_taken(ev_vec[7]),
    .err_ev(err_v), .overrange_event(ev_vec[0]), .vi_current_overload(vi),
    .good_reading(ev_vec[1]), .store_full_event(ev_vec[2]), .store_read(ev_vec[3]),
    .reading_done(ev_vec[4]), .reading_request(ev_vec[5]), .error_word_query(ev_vec[6]),
    .mask_write(ev_vec[10]), .mask_value(mask_v), .mode_write(ev_vec[11]),
    .mode_value(mode_v), .spoll_read(spoll_read), .last_byte_out(last_out),
    .status_byte(status_byte), .srq_o(srq_o), .srq_oe(srq_oe), .nrfd_o(nrfd_o),
    .nrfd_oe(nrfd_oe), .eoi_o(eoi_o), .eoi_oe(eoi_oe), .end_mode(end_mode));

  bus_controller_model ctrl (.core_clk(core_clk), .nrst(nrst), .srq_line(srq_line),
    .status_byte(status_byte), .poll_en(poll_en), .poll_delay(poll_delay),
    .spoll_read(spoll_read), .polled_byte(polled_byte), .poll_count(poll_count));

  function automatic logic [7:0] exp_sb(input logic rqs, input logic rdy);
    return {1'b0, rqs, m_err, rdy, m_done, 1'b0, m_full, m_ovf};
  endfunction : exp_sb

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic pulse(input int idx, input logic [7:0] v = 8'h00);
    @(posedge core_clk);
    ev_vec <= 12'h001 << idx;
    mask_v <= v;
    mode_v <= srq_pkg::end_mode_type'(v[1:0]);
    @(posedge core_clk);
    ev_vec <= 12'h000;
  endtask : pulse

  task automatic err_pulse();
    logic [3:0] e;
    // A zero draw would raise no error at all
    e = 4'($random(seed));
    if (e == 4'h0) e = 4'h8;
    @(posedge core_clk);
    err_v <= srq_pkg::err_events_type'(e);
    @(posedge core_clk);
    err_v <= '0;
    m_err = 1'b1;
  endtask : err_pulse

  task automatic send_byte(input logic ex, input srq_pkg::cmd_class_type cls);
    @(posedge core_clk);
    rx_v <= {1'b1, ex, cls};
    @(posedge core_clk);
    rx_v <= '0;
  endtask : send_byte

  task automatic expect_poll(input logic want);
    int c0;
    c0 = poll_count;
    for (int i = 0; i < 100 && poll_count == c0; i++) @(posedge core_clk);
    #1;
    check("poll seen", {7'h00, want}, {7'h00, poll_count != c0});
  endtask : expect_poll

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  initial begin
    #300000;
    fails++;
    $display("Error watchdog expired");
    end_of_test();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    #1;
    check("byte in reset", 8'h00, status_byte);
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    settle();
    check("byte after reset", exp_sb(0, 1), status_byte);
    check("mode after reset", 8'h00, end_mode);
    $display("Test reset done");

    for (int i = 0; i < 40; i++) begin
      op = $unsigned($random(seed)) % 8;
      r = $random(seed);
      case (op)
        0: begin
          @(posedge core_clk) vi <= r;
          pulse(0);
          if (!r) m_ovf = 1'b1;
        end
        6: err_pulse();
        7: begin
          pulse(6);
          m_err = 1'b0;
        end
        default: begin
          pulse(op);
          if (op == 1) m_ovf = 1'b0;
          if (op == 2 || op == 3) m_full = (op == 2);
          if (op == 4 || op == 5) m_done = (op == 4);
        end
      endcase
      settle();
      check("live byte", exp_sb(0, 1), status_byte);
      check("srq idle", 8'h01, srq_line);
    end
    @(posedge core_clk) clk_en <= 1'b0;
    pulse(m_done ? 5 : 4);
    @(posedge core_clk) clk_en <= 1'b1;
    settle();
    check("pulse while frozen", exp_sb(0, 1), status_byte);
    @(posedge core_clk) vi <= 1'b0;
    $display("Test live bits done");

    pulse(6);
    m_err = 1'b0;
    pulse(10, 8'h20);
    err_pulse();
    expect_poll(1);
    check("polled error", exp_sb(1, 1), polled_byte);
    settle();
    check("after poll", exp_sb(0, 1), status_byte);
    err_pulse();
    expect_poll(0);
    pulse(6);
    m_err = 1'b0;
    settle();
    check("error cleared", exp_sb(0, 1), status_byte);
    err_pulse();
    expect_poll(1);
    pulse(6);
    m_err = 1'b0;
    $display("Test error srq done");

    for (int i = 0; i < 5; i++) begin
      fr = (i == 0) ? 8'h01 : (i == 1) ? 8'h02 : (i == 2) ? 8'h08 : (i == 3) ? 8'hC4 : 8'h00;
      op = (i == 1) ? 2 : (i == 2) ? 4 : 0;
      pulse(op + 1);
      pulse(10, fr);
      settle();
      pulse(op);
      m_ovf = m_ovf | (op == 0);
      m_full = m_full | (op == 2);
      m_done = m_done | (op == 4);
      expect_poll(i < 3);
      if (i < 3) check("polled cause", exp_sb(1, 1), polled_byte);
    end
    $display("Test mask weights done");

    pulse(1);
    pulse(5);
    m_ovf = 1'b0;
    m_done = 1'b0;
    pulse(10, 8'h08);
    poll_delay <= 8'd40;
    pulse(4);
    m_done = 1'b1;
    settle();
    fr = exp_sb(1, 1);
    check("frozen byte", fr, status_byte);
    pulse(0);
    m_ovf = 1'b1;
    settle();
    check("still frozen", fr, status_byte);
    expect_poll(1);
    check("polled frozen", fr, polled_byte);
    settle();
    check("live after poll", exp_sb(0, 1), status_byte);
    poll_delay <= 8'd1;
    $display("Test freeze done");

    pulse(10, 8'h10);
    send_byte(0, srq_pkg::cls_other);
    settle();
    check("busy byte", exp_sb(0, 0), status_byte);
    pulse(8);
    expect_poll(1);
    check("polled ready", exp_sb(1, 1), polled_byte);
    pulse(10, 8'h00);
    $display("Test ready srq done");

    for (int m = 0; m < 4; m++) begin
      pulse(11, 8'(m));
      @(posedge core_clk) last_out <= 1'b1;
      settle();
      check("end mode", 8'(m), end_mode);
      check("eoi line", {7'h00, m[0] == 1}, eoi_line);
      @(posedge core_clk) last_out <= 1'b0;
      send_byte(1, m[0] ? srq_pkg::cls_config : srq_pkg::cls_cal_store);
      repeat (m[0] ? CFG - 1 : CAL - 1) @(posedge core_clk);
      #1;
      check("nrfd held", 8'h00, nrfd_line);
      repeat (8) @(posedge core_clk);
      #1;
      check("nrfd timed", {7'h00, m < 2}, nrfd_line);
      pulse(8);
      settle();
      check("nrfd released", 8'h01, nrfd_line);
    end
    pulse(11, 8'h00);
    send_byte(1, srq_pkg::cls_zero_suppress);
    repeat (60) @(posedge core_clk);
    #1;
    check("nrfd value", 8'h00, nrfd_line);
    pulse(7);
    pulse(8);
    settle();
    check("nrfd after value", 8'h01, nrfd_line);
    $display("Test holdoff done");

    @(posedge core_clk) ren_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
    send_byte(0, srq_pkg::cls_other);
    pulse(8);
    m_err = 1'b1;
    @(posedge core_clk) ren_pin <= 1'b1;
    settle();
    check("no remote error", exp_sb(0, 1), status_byte);
    pulse(10, 8'h08);
    pulse(11, 8'h03);
    pulse(9);
    m_err = 1'b0;
    settle();
    check("clear mode", 8'h00, end_mode);
    check("clear byte", exp_sb(0, 1), status_byte);
    pulse(5);
    pulse(4);
    expect_poll(0);
    $display("Test device clear done");
    end_of_test();
  end
endmodule : testbench
